// ===== rtl/crf_core.sv
// cpu register file, program counter, flag byte and stack sequencer
`timescale 1ns/1ns
// Contract
// - vector table starts at address zero, one 32-bit address per entry.
// - memory indirect jump reads a longword at the 8-bit absolute address and branches.
// - program counter is pushed and popped as a full 32-bit word.
// - exception entry and return always save and restore extended control byte.
// - fetch width selectable between 16 and 32 bits.
// - fetch width affects instruction fetches only, never data access.
// - this product always fetches at 32-bit width.
// - eight equivalent 32-bit general registers, readable at 32, 16, 8 bits.
// - each register splits into extended and plain 16-bit halves.
// - each plain half splits into upper and low bytes.
// - full, plain half and low byte views usable as index by size.
// - register 7 serves as stack pointer for implicit pushes and pops.
// - program counter holds next address, lsb forced zero on fetch.
// - bit 7 masks interrupts, resets to one, set on exception entry.
// - bit 6 is a software user bit, optionally an extra mask.
// - half-carry captures carry at bit 3, 11 or 27 by size.
// - bit 4 is a user bit without hardware effect.
// - negative flag takes the result msb.
// - zero flag set on zero result, cleared otherwise.
// - overflow flag set on arithmetic overflow, cleared otherwise.
// - carry flag records carry, borrow or shifted-out bit.
// - branch conditions use n z v c; control ops load, and, or, xor flags.
// - extended half is upper 16 bits, plain half lower 16 bits.
module crf_core
#(
  parameter int NUM_REGS = crf_pkg::CRF_NUM_REGS,
  parameter bit FORCE_FETCH32 = 1'b1
)
(
  input wire logic clk,
  input wire logic arst_n,
  input wire crf_pkg::crf_gpr_wr_t gpr_wr,
  input wire logic [2:0] rd_idx,
  input wire crf_pkg::crf_view_t rd_view,
  output logic [31:0] rd_data,
  input wire logic [2:0] idx_sel,
  input wire crf_pkg::crf_size_t idx_size,
  output logic [31:0] idx_value,
  input wire logic sp_wr_en,
  input wire logic [31:0] sp_wr_data,
  output logic [31:0] sp_value,
  input wire logic pc_load,
  input wire logic [31:0] pc_load_value,
  input wire logic pc_advance,
  input wire logic [2:0] pc_step,
  output logic [31:0] pc_value,
  output logic [31:0] fetch_addr,
  input wire logic fetch32_req,
  output logic fetch32_mode,
  input wire crf_pkg::crf_flag_op_t flag_op,
  input wire logic [7:0] flag_operand,
  input wire crf_pkg::crf_alu_in_t alu_in,
  output logic [7:0] flags_value,
  input wire logic [3:0] cond_code,
  output logic cond_true,
  input wire logic user_mask_en,
  output logic irq_masked,
  output logic [7:0] ext_ctrl_value,
  input wire logic ext_ctrl_wr,
  input wire logic [7:0] ext_ctrl_wdata,
  input wire logic call_req,
  input wire logic [31:0] call_target,
  input wire logic ret_req,
  input wire logic exc_req,
  input wire logic [7:0] exc_vector,
  input wire logic rte_req,
  input wire logic ind_jump_req,
  input wire logic ind_jump_link,
  input wire logic [7:0] ind_abs_addr,
  output crf_pkg::crf_mem_req_t mem_req,
  input wire logic mem_ack,
  input wire logic [31:0] mem_rdata,
  output logic busy
);
  import crf_pkg::*;

  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [31:0] view_read(input logic [31:0] r, input crf_view_t v);
    case (v)
      CRF_VIEW_FULL: view_read = r;
      CRF_VIEW_EXT: view_read = {16'h0000, r[31:16]};
      CRF_VIEW_UPPER: view_read = {24'h00_0000, r[15:8]};
      default: view_read = {24'h00_0000, r[7:0]};
    endcase
  endfunction

  function automatic logic [31:0] view_merge(input logic [31:0] r, input crf_view_t v,
                                             input logic [31:0] d);
    view_merge = r;
    case (v)
      CRF_VIEW_FULL: view_merge = d;
      CRF_VIEW_EXT: view_merge[31:16] = d[15:0];
      CRF_VIEW_UPPER: view_merge[15:8] = d[7:0];
      default: view_merge[7:0] = d[7:0];
    endcase
  endfunction

  // ****************************************
  // state
  // ****************************************
  logic [31:0] gpr_ff [NUM_REGS];
  logic [31:0] nxt_gpr [NUM_REGS];
  logic [31:0] pc_ff;
  logic [31:0] nxt_pc;
  logic [7:0] flags_ff;
  logic [7:0] nxt_flags;
  logic [7:0] ext_ff;
  logic [7:0] nxt_ext;
  crf_state_t state_ff;
  crf_state_t nxt_state;
  logic popping_ff;
  logic nxt_popping;
  logic link_ff;
  logic nxt_link;
  logic [31:0] tmp_ff;
  logic [31:0] nxt_tmp;
  crf_mem_req_t mem_ff;
  crf_mem_req_t nxt_mem;
  logic fetch32_ff;
  logic nxt_fetch32;
  logic [7:0] alu_flags;
  logic [31:0] sp_cur;

  crf_flag_calc crf_flag_calc_i
  (
    .alu(alu_in),
    .flags_in(flags_ff),
    .flags_out(alu_flags)
  );

  assign sp_cur = gpr_ff[CRF_SP_INDEX];

  // ****************************************
  // read side
  // ****************************************
  always_comb
  begin
    rd_data = view_read(gpr_ff[rd_idx], rd_view);
    case (idx_size)
      CRF_SZ_BYTE: idx_value = {24'h00_0000, gpr_ff[idx_sel][7:0]};
      CRF_SZ_WORD: idx_value = {16'h0000, gpr_ff[idx_sel][15:0]};
      default: idx_value = gpr_ff[idx_sel];
    endcase
    case (cond_code)
      4'h0: cond_true = 1'b1;
      4'h1: cond_true = 1'b0;
      4'h2: cond_true = ~(flags_ff[CRF_BIT_C] | flags_ff[CRF_BIT_Z]);
      4'h3: cond_true = flags_ff[CRF_BIT_C] | flags_ff[CRF_BIT_Z];
      4'h4: cond_true = ~flags_ff[CRF_BIT_C];
      4'h5: cond_true = flags_ff[CRF_BIT_C];
      4'h6: cond_true = ~flags_ff[CRF_BIT_Z];
      4'h7: cond_true = flags_ff[CRF_BIT_Z];
      4'h8: cond_true = ~flags_ff[CRF_BIT_V];
      4'h9: cond_true = flags_ff[CRF_BIT_V];
      4'ha: cond_true = ~flags_ff[CRF_BIT_N];
      4'hb: cond_true = flags_ff[CRF_BIT_N];
      4'hc: cond_true = ~(flags_ff[CRF_BIT_N] ^ flags_ff[CRF_BIT_V]);
      4'hd: cond_true = flags_ff[CRF_BIT_N] ^ flags_ff[CRF_BIT_V];
      4'he: cond_true = ~(flags_ff[CRF_BIT_Z] | (flags_ff[CRF_BIT_N] ^ flags_ff[CRF_BIT_V]));
      default: cond_true = flags_ff[CRF_BIT_Z] | (flags_ff[CRF_BIT_N] ^ flags_ff[CRF_BIT_V]);
    endcase
  end

  assign sp_value = sp_cur;
  assign pc_value = pc_ff;
  assign fetch_addr = {pc_ff[31:1], 1'b0};
  assign flags_value = flags_ff;
  assign ext_ctrl_value = ext_ff;
  assign fetch32_mode = fetch32_ff;
  // bit 4 deliberately drives nothing
  assign irq_masked = flags_ff[CRF_BIT_I] | (user_mask_en & flags_ff[CRF_BIT_UMASK]);
  assign mem_req = mem_ff;
  assign busy = (state_ff != CRF_ST_IDLE);

  // ****************************************
  // next state of registers and stack sequencer
  // ****************************************
  always_comb
  begin
    nxt_fetch32 = FORCE_FETCH32 ? 1'b1 : fetch32_req;
    nxt_gpr = gpr_ff;
    nxt_pc = pc_ff;
    nxt_flags = flags_ff;
    nxt_ext = ext_ff;
    nxt_state = state_ff;
    nxt_popping = popping_ff;
    nxt_link = link_ff;
    nxt_tmp = tmp_ff;
    nxt_mem = mem_ff;
    if (gpr_wr.en)
      nxt_gpr[gpr_wr.idx] = view_merge(gpr_ff[gpr_wr.idx], gpr_wr.view, gpr_wr.data);
    if (sp_wr_en)
      nxt_gpr[CRF_SP_INDEX] = sp_wr_data;
    if (ext_ctrl_wr)
      nxt_ext = ext_ctrl_wdata;
    case (flag_op)
      CRF_FOP_LOAD: nxt_flags = flag_operand;
      CRF_FOP_AND: nxt_flags = flags_ff & flag_operand;
      CRF_FOP_OR: nxt_flags = flags_ff | flag_operand;
      CRF_FOP_XOR: nxt_flags = flags_ff ^ flag_operand;
      CRF_FOP_ALU: nxt_flags = alu_flags;
      default: nxt_flags = flags_ff;
    endcase
    if (pc_load)
      nxt_pc = pc_load_value;
    else if (pc_advance)
      nxt_pc = pc_ff + {29'h0000_0000, pc_step};
    case (state_ff)
      CRF_ST_IDLE:
      begin
        if (exc_req)
        begin
          nxt_flags[CRF_BIT_I] = 1'b1;
          nxt_tmp = CRF_VECTOR_BASE + {22'h00_0000, exc_vector, 2'b00};
          nxt_mem = '{req: 1'b1, we: 1'b1, addr: sp_cur - 32'h0000_0004,
                      wdata: pc_ff};
          nxt_gpr[CRF_SP_INDEX] = sp_cur - 32'h0000_0004;
          nxt_popping = 1'b0;
          nxt_state = CRF_ST_PUSH_PC;
        end
        else if (call_req)
        begin
          nxt_tmp = call_target;
          nxt_mem = '{req: 1'b1, we: 1'b1, addr: sp_cur - 32'h0000_0004,
                      wdata: pc_ff};
          nxt_gpr[CRF_SP_INDEX] = sp_cur - 32'h0000_0004;
          nxt_popping = 1'b1;
          nxt_state = CRF_ST_PUSH_PC;
        end
        else if (rte_req)
        begin
          nxt_mem = '{req: 1'b1, we: 1'b0, addr: sp_cur, wdata: 32'h0000_0000};
          nxt_state = CRF_ST_POP_FLAGS;
        end
        else if (ret_req)
        begin
          nxt_mem = '{req: 1'b1, we: 1'b0, addr: sp_cur, wdata: 32'h0000_0000};
          nxt_state = CRF_ST_POP_PC;
        end
        else if (ind_jump_req)
        begin
          nxt_link = ind_jump_link;
          nxt_mem = '{req: 1'b1, we: 1'b0, addr: {24'h00_0000, ind_abs_addr},
                      wdata: 32'h0000_0000};
          nxt_state = CRF_ST_VEC;
        end
      end
      CRF_ST_PUSH_PC:
      begin
        if (mem_ack)
        begin
          if (popping_ff)
          begin
            // subroutine call: pc pushed, jump now
            nxt_mem.req = 1'b0;
            nxt_pc = tmp_ff;
            nxt_state = CRF_ST_IDLE;
          end
          else
          begin
            // exception frame: flag and control bytes share the next word
            nxt_mem = '{req: 1'b1, we: 1'b1, addr: sp_cur - 32'h0000_0004,
                        wdata: {flags_ff, ext_ff, 16'h0000}};
            nxt_gpr[CRF_SP_INDEX] = sp_cur - 32'h0000_0004;
            nxt_state = CRF_ST_PUSH_FLAGS;
          end
        end
      end
      CRF_ST_PUSH_FLAGS:
      begin
        if (mem_ack)
        begin
          nxt_link = 1'b0;
          nxt_mem = '{req: 1'b1, we: 1'b0, addr: tmp_ff, wdata: 32'h0000_0000};
          nxt_state = CRF_ST_VEC;
        end
      end
      CRF_ST_POP_FLAGS:
      begin
        if (mem_ack)
        begin
          nxt_flags = mem_rdata[31:24];
          nxt_ext = mem_rdata[23:16];
          nxt_gpr[CRF_SP_INDEX] = sp_cur + 32'h0000_0004;
          nxt_mem = '{req: 1'b1, we: 1'b0, addr: sp_cur + 32'h0000_0004,
                      wdata: 32'h0000_0000};
          nxt_state = CRF_ST_POP_PC;
        end
      end
      CRF_ST_POP_PC:
      begin
        if (mem_ack)
        begin
          nxt_pc = mem_rdata;
          nxt_gpr[CRF_SP_INDEX] = sp_cur + 32'h0000_0004;
          nxt_mem.req = 1'b0;
          nxt_state = CRF_ST_IDLE;
        end
      end
      CRF_ST_VEC:
      begin
        if (mem_ack)
        begin
          if (link_ff)
          begin
            // indirect call: push return pc, then branch to the fetched word
            nxt_tmp = mem_rdata;
            nxt_link = 1'b0;
            nxt_popping = 1'b1;
            nxt_mem = '{req: 1'b1, we: 1'b1, addr: sp_cur - 32'h0000_0004,
                        wdata: pc_ff};
            nxt_gpr[CRF_SP_INDEX] = sp_cur - 32'h0000_0004;
            nxt_state = CRF_ST_PUSH_PC;
          end
          else
          begin
            nxt_pc = mem_rdata;
            nxt_mem.req = 1'b0;
            nxt_state = CRF_ST_IDLE;
          end
        end
      end
      default: nxt_state = CRF_ST_IDLE;
    endcase
  end

  // ****************************************
  // registers
  // ****************************************
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      // general regs undefined by design; zero chosen for determinism
      gpr_ff <= '{default: CRF_GPR_RESET};
      pc_ff <= CRF_PC_RESET;
      flags_ff <= CRF_FLAGS_RESET;
      ext_ff <= CRF_EXT_CTRL_RESET;
      state_ff <= CRF_ST_IDLE;
      popping_ff <= 1'b0;
      link_ff <= 1'b0;
      tmp_ff <= 32'h0000_0000;
      mem_ff <= '0;
      fetch32_ff <= 1'b1;
    end
    else
    begin
      gpr_ff <= nxt_gpr;
      pc_ff <= nxt_pc;
      flags_ff <= nxt_flags;
      ext_ff <= nxt_ext;
      state_ff <= nxt_state;
      popping_ff <= nxt_popping;
      link_ff <= nxt_link;
      tmp_ff <= nxt_tmp;
      mem_ff <= nxt_mem;
      fetch32_ff <= nxt_fetch32;
    end
  end
endmodule // crf_core

// ===== rtl/crf_pkg.sv
// shared constants, types and enumerations of the cpu register file
package crf_pkg;
  // ****************************************
  // widths and reset values
  // ****************************************
  localparam int CRF_NUM_REGS = 8;
  localparam int CRF_SP_INDEX = 7;
  localparam logic [31:0] CRF_VECTOR_BASE = 32'h0000_0000;
  localparam logic [31:0] CRF_PC_RESET = 32'h0000_0000;
  localparam logic [31:0] CRF_GPR_RESET = 32'h0000_0000;
  localparam logic [7:0] CRF_FLAGS_RESET = 8'h80;
  localparam logic [7:0] CRF_EXT_CTRL_RESET = 8'h07;
  localparam int CRF_VEC_BYTES = 4;

  // ****************************************
  // flag byte field positions
  // ****************************************
  localparam int CRF_BIT_I = 7;
  localparam int CRF_BIT_UMASK = 6;
  localparam int CRF_BIT_H = 5;
  localparam int CRF_BIT_U = 4;
  localparam int CRF_BIT_N = 3;
  localparam int CRF_BIT_Z = 2;
  localparam int CRF_BIT_V = 1;
  localparam int CRF_BIT_C = 0;

  // ****************************************
  // enumerations
  // ****************************************
  typedef enum logic [1:0]
  {
    CRF_SZ_BYTE = 2'b00,
    CRF_SZ_WORD = 2'b01,
    CRF_SZ_LONG = 2'b10
  } crf_size_t;

  // general register view selector
  typedef enum logic [1:0]
  {
    CRF_VIEW_FULL = 2'b00,
    CRF_VIEW_EXT = 2'b01,
    CRF_VIEW_UPPER = 2'b10,
    CRF_VIEW_LOW = 2'b11
  } crf_view_t;

  typedef enum logic [2:0]
  {
    CRF_FOP_NONE = 3'b000,
    CRF_FOP_LOAD = 3'b001,
    CRF_FOP_AND = 3'b010,
    CRF_FOP_OR = 3'b011,
    CRF_FOP_XOR = 3'b100,
    CRF_FOP_ALU = 3'b101
  } crf_flag_op_t;

  typedef enum logic [1:0]
  {
    CRF_ALU_NONE = 2'b00,
    CRF_ALU_ADD = 2'b01,
    CRF_ALU_SUB = 2'b10,
    CRF_ALU_LOGIC = 2'b11
  } crf_alu_t;

  typedef enum logic [2:0]
  {
    CRF_ST_IDLE = 3'b000,
    CRF_ST_PUSH_PC = 3'b001,
    CRF_ST_PUSH_FLAGS = 3'b010,
    CRF_ST_POP_FLAGS = 3'b011,
    CRF_ST_POP_PC = 3'b100,
    CRF_ST_VEC = 3'b101
  } crf_state_t;

  // ****************************************
  // carriers
  // ****************************************
  typedef struct packed
  {
    logic en;
    logic [2:0] idx;
    crf_view_t view;
    logic [31:0] data;
  } crf_gpr_wr_t;

  typedef struct packed
  {
    logic en;
    crf_alu_t kind;
    crf_size_t size;
    logic [31:0] op_a;
    logic [31:0] op_b;
    logic [31:0] result;
    logic shift_out;
    logic shift_valid;
  } crf_alu_in_t;

  typedef struct packed
  {
    logic req;
    logic we;
    logic [31:0] addr;
    logic [31:0] wdata;
  } crf_mem_req_t;
endpackage

// ===== rtl/crf_flag_calc.sv
// condition flag computation from an alu result
`timescale 1ns/1ns
module crf_flag_calc
(
  input wire crf_pkg::crf_alu_in_t alu,
  input wire logic [7:0] flags_in,
  output logic [7:0] flags_out
);
  import crf_pkg::*;

  // ****************************************
  // msb position of an operand size
  // ****************************************
  function automatic int msb_of(input crf_size_t sz);
    case (sz)
      CRF_SZ_BYTE: msb_of = 7;
      CRF_SZ_WORD: msb_of = 15;
      default: msb_of = 31;
    endcase
  endfunction

  // half-carry sits four bits below the msb: 3, 11, 27
  function automatic int half_of(input crf_size_t sz);
    half_of = msb_of(sz) - 4;
  endfunction

  logic [32:0] sum;
  logic [31:0] carry_vec;
  logic [31:0] b_eff;
  logic sa;
  logic sb;
  logic sr;
  logic cout;
  logic half;
  logic zero;
  int m;

  always_comb
  begin
    m = msb_of(alu.size);
    b_eff = (alu.kind == CRF_ALU_SUB) ? ~alu.op_b : alu.op_b;
    sum = {1'b0, alu.op_a} + {1'b0, b_eff} + {32'h0000_0000, (alu.kind == CRF_ALU_SUB)};
    carry_vec = alu.op_a ^ b_eff ^ sum[31:0];
    sa = alu.op_a[m];
    sb = alu.op_b[m];
    sr = alu.result[m];
    // carry into bit m+1; inverted for subtraction to give a borrow
    cout = (m == 31) ? sum[32] : carry_vec[m + 1];
    half = carry_vec[half_of(alu.size) + 1];
    if (alu.kind == CRF_ALU_SUB)
    begin
      cout = ~cout;
      half = ~half;
    end
    case (alu.size)
      CRF_SZ_BYTE: zero = (alu.result[7:0] == 8'h00);
      CRF_SZ_WORD: zero = (alu.result[15:0] == 16'h0000);
      default: zero = (alu.result == 32'h0000_0000);
    endcase
    flags_out = flags_in;
    if (alu.en)
    begin
      flags_out[CRF_BIT_N] = sr;
      flags_out[CRF_BIT_Z] = zero;
      case (alu.kind)
        CRF_ALU_ADD:
        begin
          flags_out[CRF_BIT_H] = half;
          flags_out[CRF_BIT_V] = (sa == sb) && (sr != sa);
          flags_out[CRF_BIT_C] = cout;
        end
        CRF_ALU_SUB:
        begin
          flags_out[CRF_BIT_H] = half;
          flags_out[CRF_BIT_V] = (sa != sb) && (sr != sa);
          flags_out[CRF_BIT_C] = cout;
        end
        default:
        begin
          flags_out[CRF_BIT_V] = 1'b0;
          if (alu.shift_valid)
          begin
            flags_out[CRF_BIT_C] = alu.shift_out;
          end
        end
      endcase
    end
  end
endmodule // crf_flag_calc

// ===== testbench/crf_core_assertions.sv
// assertion checker bound to the cpu register file core
`timescale 1ns/1ns
module crf_core_chk
(
  input wire logic clk,
  input wire logic arst_n,
  input wire crf_pkg::crf_gpr_wr_t gpr_wr,
  input wire logic sp_wr_en,
  input wire logic [31:0] sp_value,
  input wire logic pc_load,
  input wire logic [31:0] pc_load_value,
  input wire logic [31:0] pc_value,
  input wire logic [31:0] fetch_addr,
  input wire logic fetch32_mode,
  input wire crf_pkg::crf_flag_op_t flag_op,
  input wire logic [7:0] flag_operand,
  input wire logic [7:0] flags_value,
  input wire logic [3:0] cond_code,
  input wire logic cond_true,
  input wire logic user_mask_en,
  input wire logic irq_masked,
  input wire logic call_req,
  input wire logic ret_req,
  input wire logic exc_req,
  input wire logic rte_req,
  input wire logic ind_jump_req,
  input wire crf_pkg::crf_mem_req_t mem_req,
  input wire logic mem_ack,
  input wire logic busy
);
  import crf_pkg::*;
  // ****
  // properties
  // ****
  logic quiet;
  // sequencer owns pc, sp and flags while a request is pending
  assign quiet = !busy && !(exc_req | call_req | ret_req | rte_req | ind_jump_req);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  property p_fetch_even; fetch_addr == {pc_value[31:1], 1'b0}; endproperty
  a_fetch_even: assert property (p_fetch_even) else $error("odd fetch address");
  property p_fetch32; fetch32_mode; endproperty
  a_fetch32: assert property (p_fetch32) else $error("fetch width not 32");
  property p_irq_mask; irq_masked == (flags_value[7] | (user_mask_en & flags_value[6])); endproperty
  a_irq_mask: assert property (p_irq_mask) else $error("interrupt mask wrong");
  property p_exc_imask; exc_req && !busy |=> flags_value[7]; endproperty
  a_exc_imask: assert property (p_exc_imask) else $error("mask not set on entry");
  property p_push_pc; (exc_req || call_req) && !busy |=> mem_req.req && mem_req.we
    && mem_req.addr == $past(sp_value) - 32'h0000_0004 && mem_req.wdata == $past(pc_value);
  endproperty
  a_push_pc: assert property (p_push_pc) else $error("pc push wrong");
  property p_req_hold; mem_req.req && !mem_ack |=> $stable(mem_req); endproperty
  a_req_hold: assert property (p_req_hold) else $error("request dropped early");
  property p_sp_gpr; quiet && !sp_wr_en && gpr_wr.en && gpr_wr.idx == 3'h7
    && gpr_wr.view == CRF_VIEW_FULL |=> sp_value == $past(gpr_wr.data); endproperty
  a_sp_gpr: assert property (p_sp_gpr) else $error("stack pointer not reg 7");
  property p_pc_load; quiet && pc_load |=> pc_value == $past(pc_load_value); endproperty
  a_pc_load: assert property (p_pc_load) else $error("pc load lost");
  property p_flag_load; quiet && flag_op == CRF_FOP_LOAD |=> flags_value == $past(flag_operand);
  endproperty
  a_flag_load: assert property (p_flag_load) else $error("flag load lost");
  property p_cond_eq; cond_code == 4'h7 |-> cond_true == flags_value[2]; endproperty
  a_cond_eq: assert property (p_cond_eq) else $error("equal condition wrong");
  c_exc: cover property (exc_req && !busy);
  c_call: cover property (call_req && !busy);
  c_ind: cover property (ind_jump_req && !busy ##1 busy);
endmodule // crf_core_chk

bind crf_core crf_core_chk crf_core_chk_i (.*);

// ===== testbench/cpu_register_file_and_flags_tb.sv
// self-checking testbench for the cpu register file core
`timescale 1ns/1ns
module cpu_register_file_and_flags_tb;
  import crf_pkg::*;
  // ****
  // signals and models
  // ****
  logic clk = '0;
  logic arst_n = '0;
  crf_gpr_wr_t gpr_wr = '0;
  crf_view_t rd_view = CRF_VIEW_FULL;
  crf_size_t idx_size = CRF_SZ_BYTE;
  crf_size_t s;
  crf_alu_t kd;
  crf_flag_op_t flag_op = CRF_FOP_NONE;
  crf_alu_in_t alu_in = '0;
  crf_mem_req_t mem_req;
  logic [2:0] rd_idx = '0, idx_sel = '0, pc_step = '0;
  logic [3:0] cond_code = '0;
  logic [7:0] flag_operand = '0, ext_ctrl_wdata = '0, exc_vector = '0, ind_abs_addr = '0;
  logic [7:0] fl = CRF_FLAGS_RESET;
  logic [31:0] sp_wr_data = '0, pc_load_value = '0, call_target = '0, mem_rdata = '0;
  logic sp_wr_en = '0, pc_load = '0, pc_advance = '0, fetch32_req = '0, user_mask_en = '0;
  logic ext_ctrl_wr = '0, call_req = '0, ret_req = '0, exc_req = '0, rte_req = '0;
  logic ind_jump_req = '0, ind_jump_link = '0, mem_ack = '0, fetch32_mode, cond_true;
  logic irq_masked, busy;
  logic [7:0] flags_value, ext_ctrl_value;
  logic [31:0] rd_data, idx_value, sp_value, pc_value, fetch_addr, last_rd, pv, t, rv;
  logic [32:0] a, b, r, m;
  logic [31:0] mem [logic [31:0]];
  logic [31:0] regs [8];
  int err_total = 0, n_compared = 0, dly = 0, k;

  always #2 clk = ~clk;

  crf_core crf_core_i (.*);

  function automatic logic [31:0] view(logic [31:0] o, crf_view_t v);
    case (v)
      CRF_VIEW_FULL: return o;
      CRF_VIEW_EXT: return {16'h0000, o[31:16]};
      CRF_VIEW_UPPER: return {24'h00_0000, o[15:8]};
      default: return {24'h00_0000, o[7:0]};
    endcase
  endfunction

  function automatic logic [31:0] merge(logic [31:0] o, crf_view_t v, logic [31:0] d);
    case (v)
      CRF_VIEW_FULL: return d;
      CRF_VIEW_EXT: return {d[15:0], o[15:0]};
      CRF_VIEW_UPPER: return {o[31:16], d[7:0], o[7:0]};
      default: return {o[31:8], d[7:0]};
    endcase
  endfunction

  function automatic logic [31:0] idxv(logic [31:0] o, crf_size_t z);
    return z == CRF_SZ_BYTE ? {24'h00_0000, o[7:0]} : z == CRF_SZ_WORD ? {16'h0000, o[15:0]} : o;
  endfunction

  function automatic logic condf(logic [3:0] c, logic [7:0] f);
    logic n, z, v, cy;
    logic [15:0] tt;
    {n, z, v, cy} = f[3:0];
    tt = {z | (n ^ v), !z & !(n ^ v), n ^ v, !(n ^ v), n, !n, v, !v, z, !z, cy, !cy,
      cy | z, !(cy | z), 1'b0, 1'b1};
    return tt[c];
  endfunction

  // carry and borrow both show as bit w of the widened result
  function automatic logic [7:0] alu_exp(logic [7:0] f, crf_alu_in_t x, logic c32);
    int w;
    logic [32:0] rr, q, mk;
    w = x.size == CRF_SZ_BYTE ? 8 : (x.size == CRF_SZ_WORD ? 16 : 32);
    mk = (33'h1 << w) - 33'h1;
    rr = {c32, x.result};
    q = {1'b0, x.op_a} ^ {1'b0, x.op_b} ^ rr;
    f[3] = rr[w-1];
    f[2] = (rr & mk) == '0;
    if (x.kind == CRF_ALU_LOGIC)
    begin
      f[1] = 1'b0;
      f[0] = x.shift_valid ? x.shift_out : f[0];
      return f;
    end
    f[5] = q[w-4];
    f[0] = rr[w];
    f[1] = (x.op_a[w-1] ^ x.op_b[w-1] ^ (x.kind == CRF_ALU_ADD)) && rr[w-1] != x.op_a[w-1];
    return f;
  endfunction

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask

  task end_sim;
    if (err_total == 0 && n_compared > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task run;
    @(negedge clk);
    {exc_req, call_req, ret_req, rte_req, ind_jump_req} = '0;
    for (k = 0; k < 60 && busy !== 1'b0; k++) @(negedge clk);
    chk(busy, 1'b0);
  endtask

  // ****
  // memory responder with random wait states
  // ****
  always @(negedge clk)
  begin
    rv = ~mem_rdata;
    mem_ack <= 1'b0;
    if (mem_req.req && !mem_ack && dly == 0)
    begin
      mem_ack <= 1'b1;
      dly <= $urandom % 3;
      if (mem_req.we)
        mem[mem_req.addr] = mem_req.wdata;
      else
      begin
        last_rd = mem_req.addr;
        rv = mem.exists(mem_req.addr) ? mem[mem_req.addr] : ~mem_req.addr;
      end
    end
    else if (mem_req.req && !mem_ack)
      dly <= dly - 1;
    mem_rdata <= rv;
  end

  initial
  begin
    #100000;
    err_total++;
    end_sim;
  end

  initial
  begin
    void'($urandom(78));
    foreach (regs[i]) regs[i] = CRF_GPR_RESET;
    repeat (8) @(posedge clk);
    @(negedge clk) arst_n = 1'b1;
    chk(flags_value[7], 1'b1);
    for (k = 0; k < 60; k++)
    begin
      @(negedge clk);
      rd_idx = k[0] ? gpr_wr.idx : 3'($urandom);
      gpr_wr = '{1'b1, 3'($urandom), crf_view_t'(2'($urandom)), $urandom};
      rd_view = crf_view_t'(2'($urandom));
      idx_sel = 3'($urandom);
      idx_size = crf_size_t'(2'($urandom % 3));
      fetch32_req = 1'($urandom);
      #1;
      chk(rd_data, view(regs[rd_idx], rd_view));
      chk(idx_value, idxv(regs[idx_sel], idx_size));
      chk(fetch32_mode, 1'b1);
      regs[gpr_wr.idx] = merge(regs[gpr_wr.idx], gpr_wr.view, gpr_wr.data);
    end
    for (int j = 0; j < 80; j++)
    begin
      @(negedge clk);
      gpr_wr.en = 1'b0;
      flag_op = j == 0 ? CRF_FOP_LOAD : crf_flag_op_t'(3'(1 + $urandom % 5));
      flag_operand = 8'($urandom);
      cond_code = 4'($urandom);
      user_mask_en = 1'($urandom);
      s = crf_size_t'(2'($urandom % 3));
      kd = crf_alu_t'(2'(1 + $urandom % 3));
      m = (33'h1 << (s == CRF_SZ_BYTE ? 8 : s == CRF_SZ_WORD ? 16 : 32)) - 33'h1;
      a = {1'b0, $urandom} & m;
      b = {1'b0, $urandom} & m;
      // largest positive plus one forces overflow and half carry when kd is CRF_ALU_ADD
      if (j % 8 == 1)
      begin
        a = m >> 1;
        b = 33'h1;
      end
      r = kd == CRF_ALU_ADD ? a + b : kd == CRF_ALU_SUB ? a - b : a & b;
      alu_in = '{1'b1, kd, s, a[31:0], b[31:0], r[31:0], 1'($urandom), 1'($urandom)};
      #1;
      chk(flags_value, fl);
      chk(cond_true, condf(cond_code, fl));
      chk(irq_masked, fl[7] | (user_mask_en & fl[6]));
      case (flag_op)
        CRF_FOP_LOAD: fl = flag_operand;
        CRF_FOP_AND: fl = fl & flag_operand;
        CRF_FOP_OR: fl = fl | flag_operand;
        CRF_FOP_XOR: fl = fl ^ flag_operand;
        default: fl = alu_exp(fl, alu_in, r[32]);
      endcase
    end
    @(negedge clk);
    pv = $urandom | 32'h0000_0001;
    {sp_wr_en, pc_load, pc_advance, ext_ctrl_wr} = '1;
    {sp_wr_data, pc_load_value, pc_step, ext_ctrl_wdata} = {32'h0000_1000, pv, 3'h2, 8'h85};
    flag_op = CRF_FOP_LOAD;
    flag_operand = 8'h0A;
    @(negedge clk);
    {sp_wr_en, pc_load, ext_ctrl_wr} = '0;
    flag_op = CRF_FOP_NONE;
    chk(pc_value, pv);
    chk(fetch_addr, pv & 32'hFFFF_FFFE);
    @(negedge clk);
    pc_advance = 1'b0;
    pv = pv + 32'h0000_0002;
    chk(pc_value, pv);
    exc_vector = 8'($urandom);
    t = $urandom & 32'hFFFF_FFFE;
    mem[CRF_VECTOR_BASE + 32'(exc_vector) * CRF_VEC_BYTES] = t;
    exc_req = 1'b1;
    run;
    chk(pc_value, t);
    chk(last_rd, CRF_VECTOR_BASE + 32'(exc_vector) * CRF_VEC_BYTES);
    chk(mem[32'h0000_0FFC], pv);
    chk(mem[32'h0000_0FF8][23:16], 8'h85);
    chk(sp_value, 32'h0000_0FF8);
    chk(flags_value[7], 1'b1);
    {ext_ctrl_wr, ext_ctrl_wdata, flag_operand} = {1'b1, 8'h07, 8'h3C};
    flag_op = CRF_FOP_LOAD;
    @(negedge clk);
    ext_ctrl_wr = 1'b0;
    flag_op = CRF_FOP_NONE;
    rte_req = 1'b1;
    run;
    chk(pc_value, pv);
    chk(sp_value, 32'h0000_1000);
    chk(ext_ctrl_value, 8'h85);
    chk(flags_value[6:0], 7'h0A);
    call_target = t;
    call_req = 1'b1;
    run;
    chk(pc_value, t);
    chk(mem[32'h0000_0FFC], pv);
    chk(sp_value, 32'h0000_0FFC);
    ret_req = 1'b1;
    run;
    chk(pc_value, pv);
    chk(sp_value, 32'h0000_1000);
    for (int j = 0; j < 2; j++)
    begin
      ind_abs_addr = 8'($urandom) & 8'hFC;
      t = $urandom & 32'hFFFF_FFFE;
      mem[32'(ind_abs_addr)] = t;
      {ind_jump_req, ind_jump_link} = {1'b1, j == 0};
      run;
      chk(pc_value, t);
      chk(last_rd, 32'(ind_abs_addr));
      chk(sp_value, 32'h0000_0FFC);
    end
    chk(mem[32'h0000_0FFC], pv);
    end_sim;
  end
endmodule // cpu_register_file_and_flags_tb
